// *** hw/pep_pkg.sv ***
// constants, field layout and types of the phase and error protection block.
// assumes one 50 MHz system clock and a 32-bit AHB-Lite register port.
// Operation
// - detector 0: no phase, cmp0 low sets flag
// - detector 0: no phase, cmp0 high sets nothing
// - detector 1 same, using pwm1 and cmp1
// - first phase width below threshold flags small
// - later phase pulses in period are ignored
// - phase flags set by hardware, software clears
// - nine error sources incl. software trigger
// - error active when source high and enabled
// - action priority 00 over 01 over 10 over 11
// - code 00: immediate forced pwm shutdown
// - code 01: shutdown after current period ends
// - code 10: step period down until minimum
// - code 10: shutdown after last adjusted period
// - code 11: step down, run state left alone
// - follow mode: strict minimum, ends on source drop
// - each step lowers duty by half decrement, floored at zero
// - action code changes deferred during an action
// - half decrement truncates the fraction
// - period, minimum, decrement, duty locked while adjusting
package pep_pkg;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ERRCFG = 8'h04;
  localparam logic [7:0] OFF_ACTION = 8'h08;
  localparam logic [7:0] OFF_THRESH = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_PERIOD = 8'h14;
  localparam logic [7:0] OFF_DUTY = 8'h18;
  localparam logic [7:0] OFF_MINP = 8'h1c;
  localparam logic [7:0] OFF_DEC = 8'h20;
  // ==========================================================
  // control register bit positions
  localparam int CTL_RUN = 0;
  localparam int CTL_OV0 = 1;
  localparam int CTL_OV1 = 2;
  localparam int CTL_SAFE0 = 3;
  localparam int CTL_SAFE1 = 4;
  localparam int CTL_FSHUT = 5;
  localparam int CTL_STOP = 6;
  localparam int CTL_FOLLOW = 7;
  localparam int CTL_SOFT = 8;
  // status register bit positions
  localparam int STS_ADJF = 4;
  localparam int STS_PPROT = 5;
  localparam int STS_EPROT = 6;
  localparam int STS_STATE = 7;
  localparam int STS_ACT = 9;
  // ==========================================================
  // sizes and reset values
  localparam int NSRC = 9;
  localparam int SOFT_SRC = 8;
  localparam logic [17:0] ACTION_RST = 18'h00000;
  localparam logic [15:0] VAL_RST = 16'h0000;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    ACT_NOW = 2'b00,
    ACT_END = 2'b01,
    ACT_ADJ_OFF = 2'b10,
    ACT_ADJ = 2'b11
  } pep_act_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT_END = 2'b01,
    ST_ADJUST = 2'b10
  } pep_state_t;
endpackage

// *** hw/pep_det_if.sv ***
// signals between the protection top and one phase protect detector.
// assumes all members run on the system clock.
`timescale 1ns/100ps
interface pep_det_if #(parameter int W = 10);
  logic trig;
  logic cur_cmp;
  logic phase;
  logic [W-1:0] thr;
  logic no_phase_evt;
  logic small_phase_evt;
  modport det (input trig, input cur_cmp, input phase, input thr, output no_phase_evt, output small_phase_evt);
  modport ctl (output trig, output cur_cmp, output phase, output thr, input no_phase_evt, input small_phase_evt);
endinterface

// *** hw/pep_phase_det.sv ***
// one phase protect detector: measures the first phase pulse in each
// detection period. assumes trig and phase come from same-clock logic.
`timescale 1ns/100ps
module pep_phase_det #(
  parameter int W = 10
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  pep_det_if.det p
);
  logic trig_d_ff;
  logic phase_d_ff;
  logic seen_ff;
  logic done_ff;
  logic [W-1:0] width_ff;
  logic no_ff;
  logic small_ff;
  logic trig_rise;
  logic trig_fall;
  logic end_meas;

  assign trig_rise = p.trig & ~trig_d_ff;
  assign trig_fall = ~p.trig & trig_d_ff;
  // first pulse ends on its own fall or when the period closes
  assign end_meas = !done_ff && seen_ff && ((~p.phase & phase_d_ff) || trig_fall);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trig_d_ff <= 1'b0;
      phase_d_ff <= 1'b0;
    end else begin
      trig_d_ff <= p.trig;
      phase_d_ff <= p.phase;
    end
  end

  // ==========================================================
  // width measurement
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seen_ff <= 1'b0;
      done_ff <= 1'b0;
      width_ff <= '0;
    end else if (trig_rise) begin
      seen_ff <= 1'b0;
      done_ff <= 1'b0;
      width_ff <= '0;
    end else if (p.trig && !done_ff && p.phase) begin
      seen_ff <= 1'b1;
      if (width_ff != '1) begin
        width_ff <= width_ff + 1'b1;
      end
    end else if (end_meas) begin
      done_ff <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      no_ff <= 1'b0;
      small_ff <= 1'b0;
    end else begin
      no_ff <= trig_fall && !seen_ff && !p.cur_cmp;
      small_ff <= end_meas && (width_ff < p.thr);
    end
  end

  assign p.no_phase_evt = no_ff;
  assign p.small_phase_evt = small_ff;

  // ==========================================================
  // checks
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_no_phase;
    (trig_fall && !seen_ff && !p.cur_cmp) |=> p.no_phase_evt;
  endproperty
  a_no_phase: assert property (p_no_phase) else $error("missing no-phase event");

  property p_cmp_high;
    (trig_fall && p.cur_cmp) |=> !p.no_phase_evt;
  endproperty
  a_cmp_high: assert property (p_cmp_high) else $error("no-phase event with comparator high");

  property p_ignore;
    (done_ff && !trig_rise) |=> !p.small_phase_evt ##1 !p.small_phase_evt;
  endproperty
  a_ignore: assert property (p_ignore) else $error("second phase pulse measured");
endmodule

// *** hw/pep_top.sv ***
// phase and error protection top: two phase detectors, nine-source
// error unit with shutdown and period auto-adjust, AHB-Lite registers.
// assumes pwm and phase inputs come from same-clock logic, comparators
// are asynchronous, and the master idles during each data phase.
`timescale 1ns/100ps
module pep_top import pep_pkg::*; #(
  parameter int PERIOD_W = 10
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic pwm0_i,
  input wire logic pwm1_i,
  input wire logic pwm_period_end_i,
  input wire logic phase0_i,
  input wire logic phase1_i,
  input wire logic [8:0] cmp_raw_i,
  output logic pwm_run_enable_o,
  output logic out0_override_sel_o,
  output logic out1_override_sel_o,
  output logic out0_safe_level_o,
  output logic out1_safe_level_o,
  output logic [PERIOD_W-1:0] pwm_period_o,
  output logic [PERIOD_W-1:0] pwm_duty_o,
  output logic phase_protect_sig_o,
  output logic error_protect_o,
  output logic auto_adjust_flag_o
);
  // narrower periods leave no room for a step, wider ones overflow the fields
  if (PERIOD_W < 4 || PERIOD_W > 16) begin : g_bad_width
    $error("PERIOD_W must be 4..16");
  end

  // ==========================================================
  // comparator synchronisers: value moves when stages 2 and 3 agree
  logic [8:0] cmp_sync;
  for (genvar g = 0; g < NSRC; g++) begin : g_sync
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic val_ff;
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        s1_ff <= 1'b0;
        s2_ff <= 1'b0;
        s3_ff <= 1'b0;
        val_ff <= 1'b0;
      end else begin
        s1_ff <= cmp_raw_i[g];
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
        if (s2_ff == s3_ff) begin
          val_ff <= s3_ff;
        end
      end
    end
    assign cmp_sync[g] = val_ff;
  end

  // ==========================================================
  // AHB-Lite slave: zero wait, always OKAY
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [31:0] rdata_ff;
  logic [31:0] rd_mux;
  logic addr_ok;
  assign addr_ok = hsel_i && htrans_i[1] && hready_i;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      rdata_ff <= 32'h0000_0000;
    end else begin
      wr_pend_ff <= addr_ok && hwrite_i;
      if (addr_ok) begin
        wr_addr_ff <= haddr_i[7:0];
      end
      if (addr_ok && !hwrite_i) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  logic wr_ctrl, wr_errcfg, wr_action, wr_thresh, wr_status;
  logic wr_period, wr_duty, wr_minp, wr_dec;
  assign wr_ctrl = wr_pend_ff && wr_addr_ff == OFF_CTRL;
  assign wr_errcfg = wr_pend_ff && wr_addr_ff == OFF_ERRCFG;
  assign wr_action = wr_pend_ff && wr_addr_ff == OFF_ACTION;
  assign wr_thresh = wr_pend_ff && wr_addr_ff == OFF_THRESH;
  assign wr_status = wr_pend_ff && wr_addr_ff == OFF_STATUS;
  assign wr_period = wr_pend_ff && wr_addr_ff == OFF_PERIOD;
  assign wr_duty = wr_pend_ff && wr_addr_ff == OFF_DUTY;
  assign wr_minp = wr_pend_ff && wr_addr_ff == OFF_MINP;
  assign wr_dec = wr_pend_ff && wr_addr_ff == OFF_DEC;

  // ==========================================================
  // registers
  logic run_ff, ov0_ff, ov1_ff, safe0_ff, safe1_ff, fshut_ff;
  logic stop_ff, follow_ff, soft_ff, soft_en_ff, adjf_ff;
  logic pprot_ff, eprot_ff;
  logic [7:0] src_en_ff;
  logic [17:0] action_ff;
  logic [17:0] code_ff;
  logic [3:0] flag_ff;
  logic [PERIOD_W-1:0] thr_ff, period_ff, duty_ff, min_ff, dec_ff;
  pep_state_t state_ff;
  pep_act_t cur_ff;
  logic [3:0] trg_src_ff;
  logic [8:0] act;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (haddr_i[7:0])
      OFF_CTRL: rd_mux[8:0] = {soft_ff, follow_ff, stop_ff, fshut_ff, safe1_ff, safe0_ff, ov1_ff, ov0_ff, run_ff};
      OFF_ERRCFG: rd_mux[8:0] = {soft_en_ff, src_en_ff};
      OFF_ACTION: rd_mux[17:0] = action_ff;
      OFF_THRESH: rd_mux[PERIOD_W-1:0] = thr_ff;
      OFF_STATUS: rd_mux[17:0] = {act, state_ff, eprot_ff, pprot_ff, adjf_ff, flag_ff};
      OFF_PERIOD: rd_mux[PERIOD_W-1:0] = period_ff;
      OFF_DUTY: rd_mux[PERIOD_W-1:0] = duty_ff;
      OFF_MINP: rd_mux[PERIOD_W-1:0] = min_ff;
      OFF_DEC: rd_mux[PERIOD_W-1:0] = dec_ff;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      src_en_ff <= 8'h00;
      soft_en_ff <= 1'b0;
      action_ff <= ACTION_RST;
      thr_ff <= VAL_RST[PERIOD_W-1:0];
    end else begin
      if (wr_errcfg) begin
        src_en_ff <= hwdata_i[7:0];
        soft_en_ff <= hwdata_i[8];
      end
      if (wr_action) begin
        action_ff <= hwdata_i[17:0];
      end
      if (wr_thresh) begin
        thr_ff <= hwdata_i[PERIOD_W-1:0];
      end
    end
  end

  // ==========================================================
  // phase protect detectors
  logic [1:0] no_evt, small_evt;
  for (genvar d = 0; d < 2; d++) begin : g_det
    pep_det_if #(.W(PERIOD_W)) dif ();
    assign dif.trig = (d == 0) ? pwm0_i : pwm1_i;
    assign dif.cur_cmp = cmp_sync[d];
    assign dif.phase = (d == 0) ? phase0_i : phase1_i;
    assign dif.thr = thr_ff;
    assign no_evt[d] = dif.no_phase_evt;
    assign small_evt[d] = dif.small_phase_evt;
    pep_phase_det #(.W(PERIOD_W)) u_det (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .p(dif.det)
    );
  end

  // flags are sticky; a set in the clearing cycle wins
  logic [3:0] nxt_flag;
  assign nxt_flag = (flag_ff & ~({4{wr_status}} & hwdata_i[3:0])) | {small_evt[1], no_evt[1], small_evt[0], no_evt[0]};

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_ff <= 4'h0;
      pprot_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
      pprot_ff <= |nxt_flag;
    end
  end

  // ==========================================================
  // error sources and priority search
  logic [8:0] src;
  logic [17:0] eff_code;
  logic any;
  pep_act_t best;
  logic [3:0] best_src;
  assign src = {soft_ff, cmp_sync[8:2], pprot_ff};
  assign act = src & {soft_en_ff, src_en_ff};
  // codes written mid-action wait until the action is over
  assign eff_code = (state_ff == ST_IDLE) ? action_ff : code_ff;
  assign any = |act;

  always_comb begin
    best = ACT_ADJ;
    best_src = 4'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (act[i] && eff_code[2*i +: 2] <= best) begin
        best = pep_act_t'(eff_code[2*i +: 2]);
        best_src = 4'(i);
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      code_ff <= ACTION_RST;
      eprot_ff <= 1'b0;
    end else begin
      code_ff <= eff_code;
      eprot_ff <= any;
    end
  end

  // ==========================================================
  // period arithmetic
  logic [PERIOD_W:0] diff;
  logic [PERIOD_W-1:0] half, duty_new;
  logic ok_ge, ok_gt, follow, stop_now;
  assign diff = {1'b0, period_ff} - {1'b0, dec_ff};
  assign half = dec_ff >> 1;
  assign duty_new = (duty_ff >= half) ? duty_ff - half : '0;
  assign ok_ge = !diff[PERIOD_W] && diff[PERIOD_W-1:0] >= min_ff;
  assign ok_gt = !diff[PERIOD_W] && diff[PERIOD_W-1:0] > min_ff;
  // follow mode exists only for sources 1 and 3
  assign follow = follow_ff && cur_ff == ACT_ADJ && (trg_src_ff == 4'h1 || trg_src_ff == 4'h3);
  assign stop_now = stop_ff || (follow && !src[trg_src_ff]) || !(follow ? ok_gt : ok_ge);

  // ==========================================================
  // protection state machine
  pep_state_t nxt_state;
  pep_act_t nxt_cur;
  logic [3:0] nxt_src;
  logic shut, step, start;

  always_comb begin
    nxt_state = state_ff;
    nxt_cur = cur_ff;
    nxt_src = trg_src_ff;
    shut = 1'b0;
    step = 1'b0;
    start = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (any) begin
          case (best)
            ACT_NOW: shut = 1'b1;
            ACT_END: nxt_state = ST_WAIT_END;
            default: begin
              nxt_state = ST_ADJUST;
              nxt_cur = best;
              nxt_src = best_src;
              start = 1'b1;
            end
          endcase
        end
      end
      ST_WAIT_END: begin
        if ((any && best == ACT_NOW) || pwm_period_end_i) begin
          shut = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      ST_ADJUST: begin
        if (any && best < cur_ff) begin
          nxt_cur = best;
          nxt_src = best_src;
          if (best == ACT_NOW) begin
            shut = 1'b1;
            nxt_state = ST_IDLE;
          end else if (best == ACT_END) begin
            nxt_state = ST_WAIT_END;
          end
        end else if (pwm_period_end_i) begin
          if (stop_now) begin
            shut = (cur_ff == ACT_ADJ_OFF);
            nxt_state = ST_IDLE;
          end else begin
            step = 1'b1;
          end
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= ST_IDLE;
      cur_ff <= ACT_ADJ;
      trg_src_ff <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      cur_ff <= nxt_cur;
      trg_src_ff <= nxt_src;
    end
  end

  // ==========================================================
  // control bits: hardware shutdown overrides a software write
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_ff <= 1'b0;
      ov0_ff <= 1'b0;
      ov1_ff <= 1'b0;
      safe0_ff <= 1'b0;
      safe1_ff <= 1'b0;
      fshut_ff <= 1'b0;
      stop_ff <= 1'b0;
      follow_ff <= 1'b0;
      soft_ff <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        run_ff <= hwdata_i[CTL_RUN];
        ov0_ff <= hwdata_i[CTL_OV0];
        ov1_ff <= hwdata_i[CTL_OV1];
        safe0_ff <= hwdata_i[CTL_SAFE0];
        safe1_ff <= hwdata_i[CTL_SAFE1];
        stop_ff <= hwdata_i[CTL_STOP];
        follow_ff <= hwdata_i[CTL_FOLLOW];
        soft_ff <= hwdata_i[CTL_SOFT];
      end
      fshut_ff <= shut | (fshut_ff & ~(wr_ctrl & hwdata_i[CTL_FSHUT]));
      if (shut) begin
        run_ff <= 1'b0;
        ov0_ff <= 1'b1;
        ov1_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      adjf_ff <= 1'b0;
    end else begin
      adjf_ff <= start | step | (adjf_ff & ~(wr_status & hwdata_i[STS_ADJF]));
    end
  end

  // period values are frozen for software while adjusting
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      period_ff <= VAL_RST[PERIOD_W-1:0];
      duty_ff <= VAL_RST[PERIOD_W-1:0];
      min_ff <= VAL_RST[PERIOD_W-1:0];
      dec_ff <= VAL_RST[PERIOD_W-1:0];
    end else if (step) begin
      period_ff <= diff[PERIOD_W-1:0];
      duty_ff <= duty_new;
    end else if (state_ff != ST_ADJUST) begin
      if (wr_period) period_ff <= hwdata_i[PERIOD_W-1:0];
      if (wr_duty) duty_ff <= hwdata_i[PERIOD_W-1:0];
      if (wr_minp) min_ff <= hwdata_i[PERIOD_W-1:0];
      if (wr_dec) dec_ff <= hwdata_i[PERIOD_W-1:0];
    end
  end

  assign hrdata_o = rdata_ff;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign pwm_run_enable_o = run_ff;
  assign out0_override_sel_o = ov0_ff;
  assign out1_override_sel_o = ov1_ff;
  assign out0_safe_level_o = safe0_ff;
  assign out1_safe_level_o = safe1_ff;
  assign pwm_period_o = period_ff;
  assign pwm_duty_o = duty_ff;
  assign phase_protect_sig_o = pprot_ff;
  assign error_protect_o = eprot_ff;
  assign auto_adjust_flag_o = adjf_ff;

  // ==========================================================
  // checks
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_shut_now;
    (state_ff == ST_IDLE && any && best == ACT_NOW) |=> (!pwm_run_enable_o && out0_override_sel_o && fshut_ff);
  endproperty
  a_shut_now: assert property (p_shut_now) else $error("code 00 did not shut down");

  property p_wait_end;
    (state_ff == ST_WAIT_END && pwm_period_end_i) |=> (state_ff == ST_IDLE && fshut_ff && out1_override_sel_o);
  endproperty
  a_wait_end: assert property (p_wait_end) else $error("code 01 no shutdown at period end");

  property p_step;
    step |=> (pwm_period_o == $past(period_ff) - $past(dec_ff)) && auto_adjust_flag_o;
  endproperty
  a_step: assert property (p_step) else $error("period step wrong");

  property p_duty;
    (step && duty_ff >= (dec_ff >> 1)) |=> pwm_duty_o == $past(duty_ff) - ($past(dec_ff) >> 1);
  endproperty
  a_duty: assert property (p_duty) else $error("duty step wrong");

  property p_lock;
    (state_ff == ST_ADJUST && wr_minp) |=> $stable(min_ff);
  endproperty
  a_lock: assert property (p_lock) else $error("minimum written during adjust");

  property p_end10;
    (state_ff == ST_ADJUST && cur_ff == ACT_ADJ_OFF && pwm_period_end_i && !ok_ge && !(any && best < cur_ff))
      |=> (!pwm_run_enable_o && state_ff == ST_IDLE);
  endproperty
  a_end10: assert property (p_end10) else $error("code 10 end without shutdown");

  property p_keep11;
    (state_ff == ST_ADJUST && cur_ff == ACT_ADJ && stop_now && pwm_period_end_i && !wr_ctrl && !(any && best < cur_ff))
      |=> (pwm_run_enable_o == $past(run_ff) && fshut_ff == $past(fshut_ff));
  endproperty
  a_keep11: assert property (p_keep11) else $error("code 11 changed run state");

  property p_prio;
    (state_ff == ST_ADJUST && any && best == ACT_NOW) |=> (state_ff == ST_IDLE && !pwm_run_enable_o);
  endproperty
  a_prio: assert property (p_prio) else $error("code 00 did not take over");

  property p_sticky;
    (!wr_status) |=> ((flag_ff & $past(flag_ff)) == $past(flag_ff));
  endproperty
  a_sticky: assert property (p_sticky) else $error("phase flag lost without clear");
endmodule

// *** bench/pep_pwm_model.sv ***
// pwm generator side: 16-cycle period, pwm0 high in the first half, pwm1 in
// the second, phase pulses of commanded width plus one stray late pulse.
// assumes it shares the system clock and reset with pep_top.
`timescale 1ns/100ps
module pep_pwm_model (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] ph_w_i,
  output logic pwm0_o,
  output logic pwm1_o,
  output logic pend_o,
  output logic ph0_o,
  output logic ph1_o
);
  // ==========================================================
  // period counter and outputs
  logic [3:0] cnt_ff;
  logic pulse;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= 4'h0;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end
  // stray pulse at the last high cycle catches a detector that rearms
  assign pulse = (cnt_ff[2:0] != 3'h0 && cnt_ff[2:0] <= ph_w_i) || (ph_w_i != 3'h0 && cnt_ff[2:0] == 3'h7);
  assign pwm0_o = rst_n_i & ~cnt_ff[3];
  assign pwm1_o = rst_n_i & cnt_ff[3];
  assign pend_o = cnt_ff == 4'hf;
  assign ph0_o = pwm0_o & pulse;
  assign ph1_o = pwm1_o & pulse;
endmodule

// *** bench/pep_top_bench.sv ***
// self-checking bench of pep_top: AHB-Lite master tasks, pwm model.
// assumes the zero-wait slave and the 16-cycle period of the model.
`timescale 1ns/100ps
module pep_top_bench import pep_pkg::*;;
  localparam int DEC = 31;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [8:0] cmp = 9'h3;
  logic [2:0] ph_w = 3'h5;
  logic hrdy, hresp, pend, pwm0, pwm1, ph0, ph1, run, ov0, ov1, pprot, eprot, adjf, sf0, sf1;
  logic [31:0] hrdata, rd;
  logic [9:0] per, dty;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  pep_top #(.PERIOD_W(10)) pep_top_i (.core_clk_i(clk), .rst_n_i(rst_n), .hsel_i(1'b1), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
    .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp), .pwm0_i(pwm0), .pwm1_i(pwm1),
    .pwm_period_end_i(pend), .phase0_i(ph0), .phase1_i(ph1), .cmp_raw_i(cmp), .pwm_run_enable_o(run),
    .out0_override_sel_o(ov0), .out1_override_sel_o(ov1), .out0_safe_level_o(sf0), .out1_safe_level_o(sf1),
    .pwm_period_o(per), .pwm_duty_o(dty), .phase_protect_sig_o(pprot), .error_protect_o(eprot),
    .auto_adjust_flag_o(adjf));
  pep_pwm_model pep_pwm_model_i (.core_clk_i(clk), .rst_n_i(rst_n), .ph_w_i(ph_w), .pwm0_o(pwm0),
    .pwm1_o(pwm1), .pend_o(pend), .ph0_o(ph0), .ph1_o(ph1));
  // ==========================================================
  // clock, timeout, common tasks
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // entered just after a rising edge; read data lands in rd
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  // ==========================================================
  // phase detectors: threshold 3, flags checked after a benign spell
  function automatic logic [3:0] xf(input logic [1:0] c, input logic [2:0] w);
    logic sm;
    sm = w != 3'h0 && w < 3'h3;
    return {sm, w == 3'h0 && !c[1], sm, w == 3'h0 && !c[0]};
  endfunction
  task automatic det(input logic [1:0] c, input logic [2:0] w);
    // change only at a period edge so no detector sees a cut pulse
    @(posedge clk iff pend);
    cmp[1:0] <= c;
    ph_w <= w;
    tick(32);
    cmp[1:0] <= 2'h3;
    ph_w <= 3'h5;
    tick(40);
    chk("phase_protect", xf(c, w) != 4'h0, pprot);
    ahb(1'b0, OFF_STATUS, 0);
    chk("phase_flags", xf(c, w), rd & 32'hf);
    ahb(1'b1, OFF_STATUS, 32'hf);
    ahb(1'b0, OFF_STATUS, 0);
    chk("flags_cleared", 0, rd & 32'hf);
    $display("test detector c=%h w=%h done", c, w);
  endtask
  // ==========================================================
  // error unit: trigger right after a period end, then check result
  function automatic int steps(input logic [1:0] code, input logic fol);
    return code < 2'h2 ? 0 : (fol ? 2 : 3);
  endfunction
  task automatic act(input int src, input logic [1:0] code, input logic fol, input int hold);
    logic [31:0] ctl;
    ctl = {24'h0, fol, 7'h39};
    ahb(1'b1, OFF_PERIOD, 499);
    ahb(1'b1, OFF_DUTY, 249);
    ahb(1'b1, OFF_MINP, 400);
    ahb(1'b1, OFF_DEC, DEC);
    ahb(1'b1, OFF_ERRCFG, 32'h1 << src);
    ahb(1'b1, OFF_ACTION, {30'h0, code} << (2 * src));
    ahb(1'b1, OFF_STATUS, 32'h1f);
    ahb(1'b1, OFF_CTRL, ctl);
    @(posedge clk iff pend);
    if (src == 8) ahb(1'b1, OFF_CTRL, ctl | 32'h100);
    else cmp[src + 1] <= 1'b1;
    tick(7);
    chk("run_early", code != 2'h0, run);
    chk("error_protect", 1, eprot);
    if (code[1]) ahb(1'b1, OFF_PERIOD, 32'h3ff);
    tick(hold);
    if (src == 8) ahb(1'b1, OFF_CTRL, (ctl & 32'h98) | (code == 2'h3));
    else cmp[src + 1] <= 1'b0;
    tick(160 - hold);
    ahb(1'b0, OFF_PERIOD, 0);
    chk("period", 499 - DEC * steps(code, fol), rd);
    chk("period_out", 499 - DEC * steps(code, fol), per);
    ahb(1'b0, OFF_DUTY, 0);
    chk("duty", 249 - (DEC / 2) * steps(code, fol), rd);
    chk("duty_out", 249 - (DEC / 2) * steps(code, fol), dty);
    chk("run_overrides", code == 2'h3 ? 3'h4 : 3'h3, {run, ov0, ov1});
    chk("safe_levels", 2'h3, {sf0, sf1});
    chk("adjust_flag", code[1], adjf);
    ahb(1'b0, OFF_CTRL, 0);
    chk("forced_shutdown", code != 2'h3, rd[5]);
    $display("test action src=%0d code=%h follow=%h done", src, code, fol);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'h5bb309a3));
    tick(20);
    rst_n <= 1'b1;
    tick(4);
    ahb(1'b0, OFF_CTRL, 0);
    chk("ctrl_reset", 0, rd);
    ahb(1'b0, OFF_ACTION, 0);
    chk("action_reset", ACTION_RST, rd);
    ahb(1'b1, 8'h40, 32'hffffffff);
    ahb(1'b0, 8'h40, 0);
    chk("unmapped", 0, rd);
    chk("hresp", 0, hresp);
    ahb(1'b1, OFF_THRESH, 3);
    for (int i = 0; i < 4; i++) det(i[1:0], 3'h0);
    det(2'h3, 3'h2);
    det(2'h3, 3'h3);
    det($urandom_range(3, 0), $urandom_range(5, 1));
    for (int k = 0; k < 4; k++) act($urandom_range(7, 1), k[1:0], 1'b0, 120);
    // source drops between the second and the third period end
    act(1, 2'h3, 1'b1, 24);
    act(8, 2'h0, 1'b0, 120);
    ahb(1'b1, OFF_ERRCFG, 32'h6);
    ahb(1'b1, OFF_ACTION, 32'hc);
    ahb(1'b1, OFF_CTRL, 32'h21);
    cmp[2] <= 1'b1;
    tick(30);
    chk("prio_before", 1, run);
    cmp[3] <= 1'b1;
    tick(8);
    chk("prio_after", 0, run);
    cmp[3:2] <= 2'h0;
    $display("test priority done");
    results();
  end
endmodule
